/* hw/nvm_pkg.sv */
// Constants shared by the serial programming block and its log FIFO.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package nvm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FUSE = 8'h04;
  localparam logic [7:0] ADDR_LOG = 8'h08;
  // Status field positions
  localparam int ST_LINK_ON = 0;
  localparam int ST_PROG_EN = 1;
  localparam int ST_LOCK_LO = 2;
  localparam int ST_SERIAL_EN = 4;
  localparam int ST_SHORT = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_LOG_VALID = 7;
  // Fuse register field positions
  localparam int FU_SERIAL_EN = 0;
  localparam int FU_SHORT = 1;
  // Reset and erased values
  localparam logic FUSE_SERIAL_EN_RST = 1'b0;
  localparam logic FUSE_SHORT_RST = 1'b1;
  localparam logic [1:0] LOCK_RST = 2'b11;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_READ = 8'hff;
  // Array sizes
  localparam int FLASH_WORDS = 4096;
  localparam int EE_BYTES = 512;
  localparam logic [11:0] FLASH_LAST = 12'hfff;
  // Log FIFO shape
  localparam int LOG_WIDTH = 32;
  localparam int LOG_DEPTH = 32;
  // Serial instruction bytes
  localparam logic [7:0] OP_ENABLE1 = 8'hac;
  localparam logic [7:0] OP_ENABLE2 = 8'h53;
  localparam logic [7:0] OP_ERASE = 8'h80;
  localparam logic [7:0] OP_SUB_MASK = 8'he0;
  localparam logic [7:0] OP_WLOCK = 8'he0;
  localparam logic [7:0] OP_WFUSE = 8'ha0;
  localparam logic [7:0] OP_HI_MASK = 8'hf7;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_WR_FLASH = 8'h40;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic {ST_SWEEP, ST_READY} nvm_state_t;
endpackage

/* hw/log_stream_if.sv */
// Valid/ready word stream between the programming engine and its log FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface log_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/log_fifo.sv */
// Synchronous FIFO in flip-flops, width and depth set by parameters.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module log_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  log_stream_if.snk fill,
  log_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (fill.valid && !full) begin
      store[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (fill.valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (drain.ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // log_fifo

/* hw/serial_nvm_programming.sv */
// Serial in-system programming engine with flash, EEPROM, lock bits and fuses.
// Assumes SCK, MOSI and the reset pin are asynchronous to SYS_CLK (20 MHz),
// SCK phases last more than three SYS_CLK periods, and AXI4-Lite software access.
//
// Behaviour
// - Two lock bits; only chip erase restores them. Here RST also reloads them.
// - Lock modes: none, no programming, no verify.
// - Programming-blocked mode also freezes fuse bits.
// - Serial link works only with enable fuse 0.
// - Start-up fuse 0 selects short start-up.
// - Chip erase leaves both fuses untouched.
// - Three identification bytes at addresses 0 to 2.
// - Verify lock makes identification read 0,1,2.
// - Chip erase and delivery leave arrays all-ones.
// - Byte writes; EEPROM write erases its byte.
// - Program 0x000-0xFFF, EEPROM 0x000-0x1FF.
// - Sample MOSI rising, shift MISO falling.
// - Echo second enable byte during third.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module serial_nvm_programming #(
  parameter logic [7:0] ID_BYTE0 = 8'h5a, // Arbitrary value
  parameter logic [7:0] ID_BYTE1 = 8'h6b, // Arbitrary value
  parameter logic [7:0] ID_BYTE2 = 8'h7c  // Arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic PROG_RESET_N,
  output logic MISO,
  output logic MISO_OE,
  output logic SHORT_STARTUP,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // Pin synchronisers
  logic sck_s1, sck_s2, sck_s3;
  logic mosi_s1, mosi_s2;
  logic rstn_s1, rstn_s2;
  logic sck_rise, sck_fall;

  // Nonvolatile state
  logic [15:0] flash [nvm_pkg::FLASH_WORDS];
  logic [7:0] eeprom [nvm_pkg::EE_BYTES];
  logic [1:0] lock;
  logic serial_prog_enable_fuse;
  logic short_startup_fuse;
  nvm_pkg::nvm_state_t state;
  logic [11:0] sweep_idx;

  // Serial engine
  logic link_on;
  logic [2:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] in_sr;
  logic [7:0] out_sr;
  logic [7:0] reply;
  logic [7:0] b1, b2, b3;
  logic [7:0] next_byte;
  logic byte_done;
  logic prog_en;
  logic prog_blocked;
  logic verify_blocked;
  logic [7:0] read_byte;
  logic is_enable, exec;
  logic do_erase, do_wlock, do_wfuse, do_wflash, do_wee;
  logic [11:0] flash_addr;
  logic [8:0] ee_addr;

  // Bus side
  logic aw_got, w_got;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic axi_fuse_we;
  logic [31:0] status_word;
  logic log_pop;

  log_stream_if #(.W(nvm_pkg::LOG_WIDTH)) log_in ();
  log_stream_if #(.W(nvm_pkg::LOG_WIDTH)) log_out ();

  log_fifo #(.WIDTH(nvm_pkg::LOG_WIDTH), .DEPTH(nvm_pkg::LOG_DEPTH)) u_log (
    .clk(SYS_CLK),
    .rst(RST),
    .fill(log_in.snk),
    .drain(log_out.src)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      rstn_s1 <= 1'b1;
      rstn_s2 <= 1'b1;
    end else begin
      sck_s1 <= SCK;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= MOSI;
      mosi_s2 <= mosi_s1;
      rstn_s1 <= PROG_RESET_N;
      rstn_s2 <= rstn_s1;
    end
  end

  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign link_on = !rstn_s2 && (serial_prog_enable_fuse == 1'b0);
  assign prog_blocked = (lock[0] == 1'b0);
  assign verify_blocked = (lock == 2'b00);
  assign next_byte = {in_sr[6:0], mosi_s2};
  assign byte_done = link_on && sck_rise && (bit_cnt == 3'd7);

  // Bit and byte framing, sampled on rising SCK
  always_ff @(posedge SYS_CLK) begin
    if (RST || !link_on) begin
      bit_cnt <= 3'd0;
      byte_idx <= 2'd0;
      in_sr <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      b3 <= 8'h00;
    end else if (sck_rise) begin
      in_sr <= next_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        byte_idx <= byte_idx + 2'd1;
        unique case (byte_idx)
          2'd0: b1 <= next_byte;
          2'd1: b2 <= next_byte;
          2'd2: b3 <= next_byte;
          2'd3: b1 <= b1;
        endcase
      end
    end
  end

  // Data returned in the fourth byte
  assign flash_addr = {b2[3:0], next_byte};
  assign ee_addr = {b2[0], next_byte};
  always_comb begin
    read_byte = 8'h00;
    if (prog_en) begin
      if ((b1 & nvm_pkg::OP_HI_MASK) == nvm_pkg::OP_RD_FLASH) begin
        if (verify_blocked) begin
          read_byte = nvm_pkg::BLOCKED_READ;
        end else if (b1[3]) begin
          read_byte = flash[flash_addr][15:8];
        end else begin
          read_byte = flash[flash_addr][7:0];
        end
      end else if (b1 == nvm_pkg::OP_RD_EE) begin
        read_byte = verify_blocked ? nvm_pkg::BLOCKED_READ : eeprom[ee_addr];
      end else if (b1 == nvm_pkg::OP_RD_SIG) begin
        if (verify_blocked) begin
          read_byte = {6'd0, next_byte[1:0]};
        end else begin
          unique case (next_byte[1:0])
            2'd0: read_byte = ID_BYTE0;
            2'd1: read_byte = ID_BYTE1;
            2'd2: read_byte = ID_BYTE2;
            2'd3: read_byte = 8'h00;
          endcase
        end
      end else if (b1 == nvm_pkg::OP_RD_LOCK) begin
        read_byte = {4'd0, short_startup_fuse, serial_prog_enable_fuse, lock};
      end
    end
  end

  // Reply byte picked at the last rise; echoes the first two bytes during the next one
  always_ff @(posedge SYS_CLK) begin
    if (RST || !link_on) begin
      reply <= 8'h00;
    end else if (byte_done) begin
      unique case (byte_idx)
        2'd0: reply <= next_byte;
        2'd1: reply <= next_byte;
        2'd2: reply <= read_byte;
        2'd3: reply <= 8'h00;
      endcase
    end
  end

  // MISO only moves after a falling SCK, never while SCK is high
  always_ff @(posedge SYS_CLK) begin
    if (RST || !link_on) begin
      out_sr <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt == 3'd0) begin
        out_sr <= reply;
      end else begin
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end

  assign MISO = out_sr[7];

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= link_on;
    end
  end

  // Instruction decode at the end of the fourth byte
  assign is_enable = (b1 == nvm_pkg::OP_ENABLE1) && (b2 == nvm_pkg::OP_ENABLE2);
  assign exec = byte_done && (byte_idx == 2'd3) && prog_en && !is_enable
    && (state == nvm_pkg::ST_READY) && log_in.ready;
  assign do_erase = exec && (b1 == nvm_pkg::OP_ENABLE1) && (b2 == nvm_pkg::OP_ERASE);
  assign do_wlock = exec && (b1 == nvm_pkg::OP_ENABLE1)
    && ((b2 & nvm_pkg::OP_SUB_MASK) == nvm_pkg::OP_WLOCK);
  assign do_wfuse = exec && (b1 == nvm_pkg::OP_ENABLE1)
    && ((b2 & nvm_pkg::OP_SUB_MASK) == nvm_pkg::OP_WFUSE);
  assign do_wflash = exec && ((b1 & nvm_pkg::OP_HI_MASK) == nvm_pkg::OP_WR_FLASH)
    && !prog_blocked;
  assign do_wee = exec && (b1 == nvm_pkg::OP_WR_EE) && !prog_blocked;

  always_ff @(posedge SYS_CLK) begin
    if (RST || !link_on) begin
      prog_en <= 1'b0;
    end else if (byte_done && (byte_idx == 2'd3) && is_enable) begin
      prog_en <= 1'b1;
    end
  end

  // Erase sweep; also brings the arrays up erased
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= nvm_pkg::ST_SWEEP;
      sweep_idx <= 12'd0;
    end else begin
      unique case (state)
        nvm_pkg::ST_SWEEP: begin
          sweep_idx <= sweep_idx + 12'd1;
          if (sweep_idx == nvm_pkg::FLASH_LAST) begin
            state <= nvm_pkg::ST_READY;
          end
        end
        nvm_pkg::ST_READY: begin
          sweep_idx <= 12'd0;
          if (do_erase) begin
            state <= nvm_pkg::ST_SWEEP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (state == nvm_pkg::ST_SWEEP) begin
      flash[sweep_idx] <= {nvm_pkg::ERASED_BYTE, nvm_pkg::ERASED_BYTE};
    end else if (do_wflash) begin
      if (b1[3]) begin
        flash[{b2[3:0], b3}][15:8] <= next_byte;
      end else begin
        flash[{b2[3:0], b3}][7:0] <= next_byte;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if ((state == nvm_pkg::ST_SWEEP) && (sweep_idx[11:9] == 3'd0)) begin
      eeprom[sweep_idx[8:0]] <= nvm_pkg::ERASED_BYTE;
    end else if (do_wee) begin
      eeprom[{b2[0], b3}] <= next_byte;
    end
  end

  // Lock bits: only programmed toward 0, only RST and erase return them
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lock <= nvm_pkg::LOCK_RST;
    end else if (do_erase) begin
      lock <= nvm_pkg::LOCK_RST;
    end else if (do_wlock) begin
      lock <= lock & b2[1:0];
    end
  end

  // Fuses: erase does not touch them; serial may change only start-up
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      serial_prog_enable_fuse <= nvm_pkg::FUSE_SERIAL_EN_RST;
      short_startup_fuse <= nvm_pkg::FUSE_SHORT_RST;
    end else if (axi_fuse_we) begin
      serial_prog_enable_fuse <= wdata_q[nvm_pkg::FU_SERIAL_EN];
      short_startup_fuse <= wdata_q[nvm_pkg::FU_SHORT];
    end else if (do_wfuse && !prog_blocked) begin
      short_startup_fuse <= b2[0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SHORT_STARTUP <= 1'b0;
    end else begin
      SHORT_STARTUP <= (short_startup_fuse == 1'b0);
    end
  end

  // Log of executed instructions; a full log refuses new ones
  assign log_in.valid = exec;
  assign log_in.data = {b1, b2, b3, next_byte};
  assign log_out.ready = log_pop;

  // AXI4-Lite write channels
  assign wr_fire = aw_got && w_got && !S_AXI_BVALID;
  assign axi_fuse_we = wr_fire && (awaddr_q == nvm_pkg::ADDR_FUSE) && wstrb_q[0]
    && !prog_blocked;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_got <= 1'b0;
      awaddr_q <= 8'h00;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got <= 1'b1;
      awaddr_q <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      w_got <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got <= 1'b1;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= nvm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      if ((awaddr_q == nvm_pkg::ADDR_STATUS) || (awaddr_q == nvm_pkg::ADDR_FUSE)
          || (awaddr_q == nvm_pkg::ADDR_LOG)) begin
        S_AXI_BRESP <= nvm_pkg::RESP_OKAY;
      end else begin
        S_AXI_BRESP <= nvm_pkg::RESP_DECERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // AXI4-Lite read channels
  always_comb begin
    status_word = 32'h00000000;
    status_word[nvm_pkg::ST_LINK_ON] = link_on;
    status_word[nvm_pkg::ST_PROG_EN] = prog_en;
    status_word[nvm_pkg::ST_LOCK_LO +: 2] = lock;
    status_word[nvm_pkg::ST_SERIAL_EN] = serial_prog_enable_fuse;
    status_word[nvm_pkg::ST_SHORT] = short_startup_fuse;
    status_word[nvm_pkg::ST_BUSY] = (state == nvm_pkg::ST_SWEEP);
    status_word[nvm_pkg::ST_LOG_VALID] = log_out.valid;
  end

  assign log_pop = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == nvm_pkg::ADDR_LOG);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= nvm_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= nvm_pkg::RESP_OKAY;
      if (S_AXI_ARADDR == nvm_pkg::ADDR_STATUS) begin
        S_AXI_RDATA <= status_word;
      end else if (S_AXI_ARADDR == nvm_pkg::ADDR_FUSE) begin
        S_AXI_RDATA <= {30'd0, short_startup_fuse, serial_prog_enable_fuse};
      end else if (S_AXI_ARADDR == nvm_pkg::ADDR_LOG) begin
        S_AXI_RDATA <= log_out.valid ? log_out.data : 32'h00000000;
      end else begin
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= nvm_pkg::RESP_DECERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule // serial_nvm_programming

/* testbench/serial_nvm_programming_chk.sv */
// Port assertions for the serial programming block.
// Bound to the top module from the testbench; one clock domain.
`timescale 1ns/1ps
module serial_nvm_programming_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic PROG_RESET_N,
  input wire logic MISO,
  input wire logic MISO_OE,
  input wire logic SHORT_STARTUP,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  chk_oe_off_idle:
    assert property (PROG_RESET_N [*5] |-> !MISO_OE) else $error("link driven while released");
  chk_miso_sck_high:
    assert property ((SCK && !PROG_RESET_N) [*4] |-> $stable(MISO))
    else $error("MISO moved with SCK high");
  chk_start_fuse_rst:
    assert property ($fell(RST) |-> !SHORT_STARTUP) else $error("short start-up after reset");
  chk_bvalid_hold:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("BVALID dropped");
  chk_rdata_hold:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer not held");
  chk_read_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late read");
  chk_write_answer:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[1:3] S_AXI_BVALID) else $error("late write response");
  chk_unmapped_read:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > nvm_pkg::ADDR_LOG
      |=> S_AXI_RRESP == nvm_pkg::RESP_DECERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_ready_busy:
    assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
endmodule // serial_nvm_programming_chk

/* testbench/isp_programmer.sv */
// Model of the external serial programmer driving SCK, MOSI and reset.
// Assumes the block samples these pins with its own clock; times in ns.
`timescale 1ns/1ps
module isp_programmer #(
  parameter int HALF_NS = 200,
  parameter int POWER_WAIT_NS = 20000000
) (
  output logic sck,
  output logic mosi,
  output logic rst_n,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rst_n = 1'b0;
  end

  task automatic power_up();
    #(POWER_WAIT_NS);
  endtask

  task automatic shift_word(input logic [31:0] tx, output logic [31:0] rx);
    #3;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF_NS);
      rx[i] = miso;
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    mosi = ~mosi;
  endtask

  task automatic pulse();
    #(HALF_NS);
    sck = 1'b1;
    #(HALF_NS);
    sck = 1'b0;
  endtask

  task automatic release_pin();
    rst_n = 1'b1;
  endtask

  task automatic enable(output logic ok);
    logic [31:0] rx;
    ok = 1'b0;
    for (int n = 0; n < 32 && !ok; n++) begin
      shift_word({nvm_pkg::OP_ENABLE1, nvm_pkg::OP_ENABLE2, 16'h0000}, rx);
      ok = (rx[15:8] === nvm_pkg::OP_ENABLE2);
      if (!ok) pulse();
    end
  endtask
endmodule // isp_programmer

/* testbench/serial_nvm_programming_tb.sv */
// Self-checking bench for the serial programming block.
// Assumes the programmer model drives the serial pins; AXI is driven here.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module serial_nvm_programming_tb;
  typedef struct packed {logic [31:0] tx; logic [8:0] exp;} row_t;
  localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary
  localparam logic [7:0] SIG2 = 8'h7c; // Arbitrary
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] rx, d;
  logic [1:0] r;
  logic ok;
  int err_count = 0;
  int n_checks = 0;
  wire logic sck, mosi, prst_n, miso, miso_oe, short_st, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  row_t rows[24] = '{
    '{32'h280fff00, 9'h1ff}, '{32'h400fff12, 9'h000}, '{32'h200fff00, 9'h112},
    '{32'hc001ff34, 9'h000}, '{32'hc001ff56, 9'h000}, '{32'ha001ff00, 9'h156},
    '{32'h30000200, {1'b1, SIG2}}, '{32'h58000000, 9'h10b}, '{32'haca00000, 9'h000},
    '{32'h58000000, 9'h103}, '{32'hace20000, 9'h000}, '{32'h58000000, 9'h102},
    '{32'h400010aa, 9'h000}, '{32'h20001000, 9'h1ff}, '{32'haca10000, 9'h000},
    '{32'h58000000, 9'h102}, '{32'hc0000577, 9'h000}, '{32'ha0000500, 9'h1ff},
    '{32'hace00000, 9'h000}, '{32'h58000000, 9'h100}, '{32'h200fff00, 9'h1ff},
    '{32'h30000000, 9'h100}, '{32'h30000100, 9'h101}, '{32'h30000200, 9'h102}};

  always #25 clk = ~clk;

  serial_nvm_programming #(.ID_BYTE0(SIG0), .ID_BYTE2(SIG2)) i_dut (
    .SYS_CLK(clk), .RST(rst), .SCK(sck), .MOSI(mosi), .PROG_RESET_N(prst_n),
    .MISO(miso), .MISO_OE(miso_oe), .SHORT_STARTUP(short_st),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // Undriven MISO line shows the inverse so stale levels never look valid
  isp_programmer #(.POWER_WAIT_NS(250000)) i_prog (
    .sck(sck), .mosi(mosi), .rst_n(prst_n), .miso(miso_oe ? miso : ~miso));

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic ser(input logic [31:0] tx, input logic [8:0] e);
    i_prog.shift_word(tx, rx);
    `CHK(rx[23:16], tx[31:24])
    if (e[8]) `CHK(rx[7:0], e[7:0])
  endtask

  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #4000000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(nvm_pkg::ADDR_FUSE, d, r);
    `CHK(d, {30'h0, nvm_pkg::FUSE_SHORT_RST, nvm_pkg::FUSE_SERIAL_EN_RST})
    `CHK(short_st, 1'b0)
    i_prog.power_up();
    i_prog.shift_word(32'h30000100, rx);
    `CHK(rx[7:0], 8'h00)
    i_prog.enable(ok);
    `CHK(ok, 1'b1)
    axi_rd(nvm_pkg::ADDR_STATUS, d, r);
    `CHK(d[nvm_pkg::ST_PROG_EN], 1'b1)
    foreach (rows[i]) ser(rows[i].tx, rows[i].exp);
    `CHK(short_st, 1'b1)
    axi_wr(nvm_pkg::ADDR_FUSE, 32'h3, r);
    axi_rd(nvm_pkg::ADDR_FUSE, d, r);
    `CHK(d, 32'h0)
    i_prog.shift_word({nvm_pkg::OP_ENABLE1, nvm_pkg::OP_ERASE, 16'h0}, rx);
    do axi_rd(nvm_pkg::ADDR_STATUS, d, r); while (d[nvm_pkg::ST_BUSY] !== 1'b0);
    ser(32'h58000000, 9'h103);
    ser(32'h200fff00, 9'h1ff);
    ser(32'ha001ff00, 9'h1ff);
    ser(32'h30000000, {1'b1, SIG0});
    `CHK(short_st, 1'b1)
    // Empty the log, then overfill it by one instruction
    do axi_rd(nvm_pkg::ADDR_LOG, d, r); while (d !== 32'h0);
    repeat (nvm_pkg::LOG_DEPTH + 1) i_prog.shift_word(32'h30000100, rx);
    for (int k = 0; k <= nvm_pkg::LOG_DEPTH; k++) begin
      axi_rd(nvm_pkg::ADDR_LOG, d, r);
      `CHK(d, (k < nvm_pkg::LOG_DEPTH) ? 32'h30000100 : 32'h0)
    end
    axi_wr(8'h20, 32'h1, r);
    `CHK(r, nvm_pkg::RESP_DECERR)
    axi_rd(8'h20, d, r);
    `CHK({r, d}, {nvm_pkg::RESP_DECERR, 32'h0})
    // Mid-run reset: fuses back to defaults, arrays swept again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(nvm_pkg::ADDR_FUSE, d, r);
    `CHK(d, {30'h0, nvm_pkg::FUSE_SHORT_RST, nvm_pkg::FUSE_SERIAL_EN_RST})
    `CHK(short_st, 1'b0)
    axi_rd(nvm_pkg::ADDR_STATUS, d, r);
    `CHK(d[nvm_pkg::ST_BUSY], 1'b1)
    axi_wr(nvm_pkg::ADDR_FUSE, 32'h1, r);
    repeat (4) @(posedge clk);
    axi_rd(nvm_pkg::ADDR_STATUS, d, r);
    `CHK({d[nvm_pkg::ST_LINK_ON], miso_oe}, 2'b00)
    i_prog.release_pin();
    i_prog.enable(ok);
    `CHK(ok, 1'b0)
    wrap_up();
  end
endmodule // serial_nvm_programming_tb

bind serial_nvm_programming serial_nvm_programming_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .SCK(SCK), .PROG_RESET_N(PROG_RESET_N), .MISO(MISO),
  .MISO_OE(MISO_OE), .SHORT_STARTUP(SHORT_STARTUP), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
